// >>> qpfs_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module qpfs_mem_model (
  input  wire logic        i_clk_sys,
  input  wire logic [12:0] i_prog_addr,
  input  wire logic        i_prog_rd,
  output logic      [13:0] o_prog_data,
  input  wire logic [6:0]  i_data_addr,
  input  wire logic        i_data_rd,
  input  wire logic        i_data_wr,
  input  wire logic [7:0]  i_data_wdata,
  output logic      [7:0]  o_data_rdata,
  output logic      [6:0]  o_last_waddr,
  output logic      [7:0]  o_last_wdata
);
  assign o_prog_data = i_prog_rd ? {i_prog_addr, 1'b1} : ~{i_prog_addr, 1'b1};
  // idle bus shows inverse, not a stale value
  assign o_data_rdata = {1'b0, i_data_addr} ^ (i_data_rd ? 8'h3C : 8'hC3);
  always @(posedge i_clk_sys) begin
    if (i_data_wr) begin
      o_last_waddr <= i_data_addr;
      o_last_wdata <= i_data_wdata;
    end
  end
endmodule
`default_nettype wire

// >>> qpfs_phase_gen.v
`timescale 1ns/1ps
`default_nettype none
`include "qpfs_regs.vh"

module qpfs_phase_gen (
  input  wire i_clk_sys,
  input  wire i_sys_rst,
  input  wire i_hold,
  output reg  o_phase_1,
  output reg  o_phase_2,
  output reg  o_phase_3,
  output reg  o_phase_4,
  output reg  o_cycle_clock
);

  reg [`QPFS_PH_W-1:0] phase;
  reg [`QPFS_PH_W-1:0] next_phase;

  always @* begin
    if (i_hold) begin
      next_phase = `QPFS_PH_1;
    end else begin
      next_phase = phase + 2'h1;
    end
  end

  // one-hot strobes registered, so no glitch between phases
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      phase         <= `QPFS_PH_4;
      o_phase_1     <= 1'b0;
      o_phase_2     <= 1'b0;
      o_phase_3     <= 1'b0;
      o_phase_4     <= 1'b0;
      o_cycle_clock <= 1'b0;
    end else begin
      phase         <= i_hold ? `QPFS_PH_4 : next_phase;
      o_phase_1     <= !i_hold && (next_phase == `QPFS_PH_1);
      o_phase_2     <= !i_hold && (next_phase == `QPFS_PH_2);
      o_phase_3     <= !i_hold && (next_phase == `QPFS_PH_3);
      o_phase_4     <= !i_hold && (next_phase == `QPFS_PH_4);
      // high in phase_1 and phase_2: square wave at quarter rate
      o_cycle_clock <= !i_hold && ((next_phase == `QPFS_PH_1) || (next_phase == `QPFS_PH_2));
    end
  end

endmodule
`default_nettype wire

// >>> qpfs_regs.vh
`ifndef QPFS_REGS_VH
`define QPFS_REGS_VH

// program and data space
`define QPFS_PC_W           13
`define QPFS_INSN_W         14
`define QPFS_DATA_W         8
`define QPFS_DADDR_W        7
`define QPFS_EE_ADDR_W      6
`define QPFS_RESET_VECTOR   13'h0000
`define QPFS_IRQ_VECTOR     13'h0004
`define QPFS_SMALL_MASK     13'h01FF
`define QPFS_LARGE_MASK     13'h03FF

// phase encoding
`define QPFS_PH_W           2
`define QPFS_PH_1           2'h0
`define QPFS_PH_2           2'h1
`define QPFS_PH_3           2'h2
`define QPFS_PH_4           2'h3

// reset values
`define QPFS_IR_RESET       14'h0000
`define QPFS_EE_PTR_RESET   6'h00
`define QPFS_DADDR_RESET    7'h00
`define QPFS_DATA_RESET     8'h00

`endif

// >>> qpfs_seq_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "qpfs_regs.vh"
module qpfs_seq_chk (
  input wire logic        i_clk_sys,
  input wire logic        i_sys_rst,
  input wire logic        i_master_reset_n,
  input wire logic        i_rc_mode,
  input wire logic        i_large_array,
  input wire logic [12:0] o_prog_addr,
  input wire logic        o_prog_rd,
  input wire logic        o_insn_valid,
  input wire logic        o_exec_decode,
  input wire logic        i_branch,
  input wire logic        i_irq_accept,
  input wire logic        o_data_rd,
  input wire logic        o_osc_out,
  input wire logic        o_phase_1,
  input wire logic        o_phase_2,
  input wire logic        o_phase_3,
  input wire logic        o_phase_4
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  a_phase_onehot: assert property (
    $onehot0({o_phase_1, o_phase_2, o_phase_3, o_phase_4})) else $error("phases overlap");
  a_phase_order: assert property (
    o_phase_1 && i_master_reset_n |=> o_phase_2) else $error("phase_2 missing");
  a_phase_wrap: assert property (
    o_phase_4 && i_master_reset_n |=> o_phase_1) else $error("phase_1 missing");
  a_reset_hold: assert property (
    !i_master_reset_n |=> !(o_phase_1 || o_phase_2 || o_prog_rd)) else $error("runs in reset");
  a_reset_vector: assert property (
    $rose(i_master_reset_n) |=> o_phase_1 ##1 (o_prog_rd && o_prog_addr == 13'h0000))
    else $error("first fetch not at zero");
  a_irq_vector: assert property (
    o_exec_decode && o_phase_4 && i_irq_accept |=> ##1 o_prog_addr == 13'h0004)
    else $error("interrupt vector wrong");
  a_fetch_window: assert property (
    o_prog_rd == (o_phase_2 || o_phase_3 || o_phase_4)) else $error("fetch strobe wrong");
  a_addr_wrap: assert property (
    o_prog_rd |-> (o_prog_addr & ~(i_large_array ? 13'h03FF : 13'h01FF)) == 13'h0000)
    else $error("address not wrapped");
  a_data_read: assert property (
    o_data_rd |-> o_phase_2) else $error("operand read off phase_2");
  a_exec_window: assert property (
    disable iff (i_sys_rst || !i_master_reset_n)
    o_exec_decode && o_phase_2 |=> o_exec_decode ##1 o_exec_decode)
    else $error("decode window broken");
  a_branch_flush: assert property (
    o_exec_decode && o_phase_4 && (i_branch || i_irq_accept) |=> ##1 !o_insn_valid)
    else $error("fetched word not flushed");
  a_osc_duty: assert property (
    $rose(o_osc_out) |-> o_osc_out [*2] ##1 !o_osc_out [*2]) else $error("clock out duty");
  a_osc_off: assert property (
    !i_rc_mode && !$past(i_rc_mode) |-> !o_osc_out) else $error("clock out without RC");
endmodule
bind qpfs_sequencer qpfs_seq_chk u_chk (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
  .i_master_reset_n(i_master_reset_n), .i_rc_mode(i_rc_mode), .i_large_array(i_large_array),
  .o_prog_addr(o_prog_addr), .o_prog_rd(o_prog_rd), .o_insn_valid(o_insn_valid),
  .o_exec_decode(o_exec_decode), .i_branch(i_branch), .i_irq_accept(i_irq_accept),
  .o_data_rd(o_data_rd), .o_osc_out(o_osc_out), .o_phase_1(o_phase_1),
  .o_phase_2(o_phase_2), .o_phase_3(o_phase_3), .o_phase_4(o_phase_4));
`default_nettype wire

// >>> qpfs_sequencer.v
// How it works
// RL1 - divide clock by four into four non-overlapping phase strobes
// RL2 - program counter advances in phase_1 of each instruction cycle
// RL3 - fetched word captured at phase_4, held from next phase_1
// RL4 - held instruction loaded at phase_1, executed over phases two to four
// RL5 - data operand read in phase_2, destination write in phase_4
// RL6 - next fetch overlaps current execute, one instruction per cycle
// RL7 - program counter change flushes fetched word, costing two cycles
// RL8 - in RC mode the clock-out pin runs at quarter input rate
// RL9 - program counter thirteen bits, instruction words fourteen bits
// RL10 - addresses above implemented array wrap, upper bits ignored
// RL11 - fetch starts at 0000h after reset, interrupt goes to 0004h
// RL12 - low master reset input resets the whole device; here fetch_word and o_insn keep their values while their valid flags clear
// RL13 - program and data memories use independent buses
// RL14 - data EEPROM reached only through a six-bit address pointer
// RL15 - each fetched instruction word is fourteen bits wide
// RL16 - reset holds phase at first phase and suppresses fetches; here phase parks at phase_4 with all strobes low
`timescale 1ns/1ps
`default_nettype none
`include "qpfs_regs.vh"

module qpfs_sequencer (
  input  wire                        i_clk_sys,
  input  wire                        i_sys_rst,
  input  wire                        i_master_reset_n,
  input  wire                        i_rc_mode,
  input  wire                        i_large_array,
  // program memory bus
  output reg  [`QPFS_PC_W-1:0]       o_prog_addr,
  output reg                         o_prog_rd,
  input  wire [`QPFS_INSN_W-1:0]     i_prog_data,
  // execute side handshake
  output reg  [`QPFS_INSN_W-1:0]     o_insn,
  output reg                         o_insn_valid,
  output wire                        o_exec_decode,
  input  wire                        i_branch,
  input  wire [`QPFS_PC_W-1:0]       i_branch_target,
  input  wire                        i_irq_accept,
  // data memory bus
  input  wire [`QPFS_DADDR_W-1:0]    i_data_addr,
  input  wire [`QPFS_DATA_W-1:0]     i_data_wdata,
  input  wire                        i_data_we_req,
  output reg  [`QPFS_DADDR_W-1:0]    o_data_addr,
  output reg                         o_data_rd,
  output reg                         o_data_wr,
  output reg  [`QPFS_DATA_W-1:0]     o_data_wdata,
  input  wire [`QPFS_DATA_W-1:0]     i_data_rdata,
  output reg  [`QPFS_DATA_W-1:0]     o_operand,
  // eeprom pointer path
  input  wire                        i_ee_ptr_we,
  input  wire [`QPFS_EE_ADDR_W-1:0]  i_ee_ptr,
  output reg  [`QPFS_EE_ADDR_W-1:0]  o_ee_addr,
  // clock-out pin and phase strobes
  output reg                         o_osc_out,
  output wire                        o_phase_1,
  output wire                        o_phase_2,
  output wire                        o_phase_3,
  output wire                        o_phase_4
);

  wire                     hold;
  wire                     cyc_clk;
  reg  [`QPFS_PC_W-1:0]    program_counter;
  reg  [`QPFS_PC_W-1:0]    next_pc;
  reg  [`QPFS_INSN_W-1:0]  fetch_word;
  reg                      fetch_valid;
  wire                     redirect;
  wire [`QPFS_PC_W-1:0]    addr_mask;

  // RL12 master reset level
  assign hold = i_sys_rst | ~i_master_reset_n;

  // RL1 phase divider
  qpfs_phase_gen u_phase (
    .i_clk_sys     (i_clk_sys),
    .i_sys_rst     (i_sys_rst),
    .i_hold        (hold),
    .o_phase_1     (o_phase_1),
    .o_phase_2     (o_phase_2),
    .o_phase_3     (o_phase_3),
    .o_phase_4     (o_phase_4),
    .o_cycle_clock (cyc_clk)
  );

  // RL10 wrap to implemented size
  assign addr_mask = i_large_array ? `QPFS_LARGE_MASK : `QPFS_SMALL_MASK;

  // RL4 decode window phases 2..4
  assign o_exec_decode = o_insn_valid & (o_phase_2 | o_phase_3 | o_phase_4);

  // RL7 redirect wins over increment
  always @* begin
    if (i_irq_accept) begin
      next_pc = `QPFS_IRQ_VECTOR;
    end else if (i_branch) begin
      next_pc = i_branch_target;
    end else begin
      next_pc = program_counter + 13'h0001;
    end
  end

  // RL7 taken branch or interrupt, sampled in phase_4
  assign redirect = o_exec_decode & o_phase_4 & (i_branch | i_irq_accept);

  // RL9 thirteen-bit counter; RL16 reset parks fetch
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      program_counter <= `QPFS_RESET_VECTOR;
    end else if (!i_master_reset_n) begin
      // RL11 restart at reset vector
      program_counter <= `QPFS_RESET_VECTOR;
    end else if (redirect) begin
      // RL11 RL7 redirect next fetch
      program_counter <= next_pc;
    end else if (o_phase_1) begin
      // RL2 advance counter
      program_counter <= program_counter + 13'h0001;
    end
  end

  // RL6 RL13 fetch address out while executing
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_prog_addr <= `QPFS_RESET_VECTOR;
      o_prog_rd   <= 1'b0;
    end else if (!i_master_reset_n) begin
      o_prog_addr <= `QPFS_RESET_VECTOR;
      o_prog_rd   <= 1'b0;
    end else if (o_phase_1) begin
      // RL10 only implemented bits leave the block
      o_prog_addr <= program_counter & addr_mask;
      o_prog_rd   <= 1'b1;
    end else if (o_phase_4) begin
      // strobe drops on the edge that takes the word
      o_prog_rd <= 1'b0;
    end
  end

  // RL3 RL15 capture fourteen-bit word
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fetch_word  <= `QPFS_IR_RESET;
      fetch_valid <= 1'b0;
    end else if (!i_master_reset_n) begin
      // stale word kept, fetch_valid hides it
      fetch_valid <= 1'b0;
    end else if (o_phase_4) begin
      fetch_word  <= i_prog_data;
      // RL7 drop word fetched before redirect
      fetch_valid <= ~redirect;
    end
  end

  // RL4 load held word into instruction register
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_insn       <= `QPFS_IR_RESET;
      o_insn_valid <= 1'b0;
    end else if (!i_master_reset_n) begin
      o_insn_valid <= 1'b0;
    end else if (o_phase_1) begin
      o_insn       <= fetch_word;
      o_insn_valid <= fetch_valid;
    end
  end

  // RL5 operand read and destination write
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_data_addr  <= `QPFS_DADDR_RESET;
      o_data_rd    <= 1'b0;
      o_data_wr    <= 1'b0;
      o_data_wdata <= `QPFS_DATA_RESET;
      o_operand    <= `QPFS_DATA_RESET;
    end else if (!i_master_reset_n) begin
      // RL12 master reset clears the data bus
      o_data_addr  <= `QPFS_DADDR_RESET;
      o_data_rd    <= 1'b0;
      o_data_wr    <= 1'b0;
      o_data_wdata <= `QPFS_DATA_RESET;
      o_operand    <= `QPFS_DATA_RESET;
    end else begin
      // fetch_valid is the slot entering o_insn, so flushed slots never read
      o_data_rd <= fetch_valid & o_phase_1;
      o_data_wr <= o_insn_valid & o_phase_3 & i_data_we_req;
      if (o_phase_1 | o_phase_3) begin
        o_data_addr <= i_data_addr;
      end
      if (o_phase_3) begin
        o_data_wdata <= i_data_wdata;
      end
      // operand lands at end of phase_2
      if (o_data_rd) begin
        o_operand <= i_data_rdata;
      end
    end
  end

  // RL14 pointer only path to eeprom
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ee_addr <= `QPFS_EE_PTR_RESET;
    end else if (!i_master_reset_n) begin
      o_ee_addr <= `QPFS_EE_PTR_RESET;
    end else if (i_ee_ptr_we) begin
      o_ee_addr <= i_ee_ptr;
    end
  end

  // RL8 clock-out only in RC mode
  // registered so the pin never glitches
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_osc_out <= 1'b0;
    end else begin
      o_osc_out <= i_rc_mode & cyc_clk;
    end
  end

endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "qpfs_regs.vh"
`define CHK(n,e,a) begin comparisons++; if ((a)!==(e)) begin num_errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module tb;
  logic i_clk_sys=0, i_sys_rst=1, i_master_reset_n=0, i_rc_mode=0, i_large_array=0;
  logic i_branch=0, i_irq_accept=0, i_data_we_req=0, i_ee_ptr_we=0;
  logic [12:0] i_branch_target=0;
  logic [6:0]  i_data_addr=0;
  logic [7:0]  i_data_wdata=0;
  logic [5:0]  i_ee_ptr=0;
  wire  [13:0] i_prog_data, o_insn;
  wire  [12:0] o_prog_addr;
  wire  [7:0]  i_data_rdata, o_data_wdata, o_operand, lwd;
  wire  [6:0]  o_data_addr, lwa;
  wire  [5:0]  o_ee_addr;
  wire o_prog_rd, o_insn_valid, o_exec_decode, o_data_rd, o_data_wr, o_osc_out;
  wire o_phase_1, o_phase_2, o_phase_3, o_phase_4;
  int num_errors=0, comparisons=0;
  qpfs_sequencer dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_master_reset_n(i_master_reset_n), .i_rc_mode(i_rc_mode), .i_large_array(i_large_array),
    .o_prog_addr(o_prog_addr), .o_prog_rd(o_prog_rd), .i_prog_data(i_prog_data),
    .o_insn(o_insn), .o_insn_valid(o_insn_valid), .o_exec_decode(o_exec_decode),
    .i_branch(i_branch), .i_branch_target(i_branch_target), .i_irq_accept(i_irq_accept),
    .i_data_addr(i_data_addr), .i_data_wdata(i_data_wdata), .i_data_we_req(i_data_we_req),
    .o_data_addr(o_data_addr), .o_data_rd(o_data_rd), .o_data_wr(o_data_wr),
    .o_data_wdata(o_data_wdata), .i_data_rdata(i_data_rdata), .o_operand(o_operand),
    .i_ee_ptr_we(i_ee_ptr_we), .i_ee_ptr(i_ee_ptr), .o_ee_addr(o_ee_addr),
    .o_osc_out(o_osc_out), .o_phase_1(o_phase_1), .o_phase_2(o_phase_2),
    .o_phase_3(o_phase_3), .o_phase_4(o_phase_4));
  qpfs_mem_model mem (.i_clk_sys(i_clk_sys), .i_prog_addr(o_prog_addr),
    .i_prog_rd(o_prog_rd), .o_prog_data(i_prog_data), .i_data_addr(o_data_addr),
    .i_data_rd(o_data_rd), .i_data_wr(o_data_wr), .i_data_wdata(o_data_wdata),
    .o_data_rdata(i_data_rdata), .o_last_waddr(lwa), .o_last_wdata(lwd));
  initial forever #4 i_clk_sys = ~i_clk_sys;
  task tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task summarize;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task t_reset;
    tick(6);
    `CHK("phases", 4'h0, {o_phase_1, o_phase_2, o_phase_3, o_phase_4})
    i_master_reset_n = 1;
    tick(1);
    `CHK("phase_1", 1'b1, o_phase_1)
    tick(1);
    `CHK("addr0", 13'h0000, o_prog_addr)
    tick(4);
    `CHK("addr1", 13'h0001, o_prog_addr)
    `CHK("insn0", 14'h0001, o_insn)
    `CHK("valid", 1'b1, o_insn_valid)
    tick(4);
    `CHK("insn1", 14'h0003, o_insn)
  endtask
  task t_mreset;
    i_master_reset_n = 0;
    tick(2);
    `CHK("mr phases", 4'h0, {o_phase_1, o_phase_2, o_phase_3, o_phase_4})
    `CHK("mr valid", 1'b0, o_insn_valid)
    `CHK("mr fetch", 1'b0, o_prog_rd)
    i_master_reset_n = 1;
    tick(1);
    `CHK("mr phase_1", 1'b1, o_phase_1)
    tick(1);
    `CHK("mr addr", `QPFS_RESET_VECTOR, o_prog_addr)
    tick(4);
    `CHK("mr insn", 14'h0001, o_insn)
    `CHK("mr insn valid", 1'b1, o_insn_valid)
  endtask
  // irq set with branch high too, so it must win
  task t_jump(input logic irq, input logic [12:0] tgt, input logic [12:0] exp);
    for (int k = 0; k < 40 && !(o_phase_4 && o_exec_decode); k++) tick(1);
    i_branch = 1;
    i_irq_accept = irq;
    i_branch_target = tgt;
    tick(1);
    i_branch = 0;
    i_irq_accept = 0;
    tick(1);
    `CHK("target", exp, o_prog_addr)
    `CHK("flushed", 1'b0, o_insn_valid)
    tick(4);
    `CHK("new insn", {exp, 1'b1}, o_insn)
  endtask
  task t_data;
    i_data_addr = 7'h2C;
    i_data_wdata = 8'h5A;
    i_data_we_req = 1;
    tick(12);
    i_data_we_req = 0;
    `CHK("wr addr", 7'h2C, lwa)
    `CHK("wr data", 8'h5A, lwd)
    `CHK("operand", 8'h10, o_operand)
  endtask
  task t_misc;
    int hi;
    hi = 0;
    i_ee_ptr = 6'h3F;
    i_ee_ptr_we = 1;
    tick(1);
    i_ee_ptr_we = 0;
    tick(1);
    `CHK("ee ptr", 6'h3F, o_ee_addr)
    `CHK("osc off", 1'b0, o_osc_out)
    i_rc_mode = 1;
    tick(8);
    for (int k = 0; k < 16; k++) begin
      tick(1);
      hi += o_osc_out;
    end
    `CHK("osc highs", 8, hi)
  endtask
  initial begin
    #5000;
    num_errors++;
    summarize();
  end
  initial begin
    tick(4);
    i_sys_rst = 0;
    t_reset();
    t_jump(1'b0, 13'h1234, 13'h0034);
    i_large_array = 1;
    t_jump(1'b0, 13'h1C20, 13'h0020);
    t_jump(1'b1, 13'h0100, `QPFS_IRQ_VECTOR);
    t_data();
    t_mreset();
    t_misc();
    summarize();
  end
endmodule
`default_nettype wire
